// >>> design/fcie_filter.sv
// Input synchroniser and hold-time filter for one channel
`timescale 1ns/1ps
`default_nettype none
module fcie_filter
    import fcie_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    input wire logic [DLY_W-1:0] delay_cycles,
    output logic level
);
    logic s1_r;
    logic s2_r;
    logic [DLY_W-1:0] cnt_r;
    wire differ = (s2_r != level);
    wire held = differ && (cnt_r + 20'h00001 >= delay_cycles);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            cnt_r <= '0;
            level <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            cnt_r <= (differ && !held) ? cnt_r + 20'h00001 : '0;
            if (held) begin
                level <= s2_r;
            end
        end
    end

    property p_hold_before_change;
        @(posedge ref_clk) disable iff (rst)
        $changed(level) |-> ($past(cnt_r) + 20'h00001 >= $past(delay_cycles));
    endproperty
    a_hold_before_change: assert property (p_hold_before_change) else $error("level changed early");
endmodule
`default_nettype wire

// >>> design/fcie_pkg.sv
// Shared constants and types of the four-channel input edge event unit
package fcie_pkg;
    localparam int CLK_MHZ = 250;
    localparam int NCH = 4;
    // Filter delay codes and their times in microseconds
    localparam logic [7:0] CODE_1US = 8'h00;
    localparam logic [7:0] CODE_3US = 8'h02;
    localparam logic [7:0] CODE_10US = 8'h04;
    localparam logic [7:0] CODE_86US = 8'h07;
    localparam logic [7:0] CODE_342US = 8'h09;
    localparam logic [7:0] CODE_2731US = 8'h0c;
    localparam int T_1US = 1;
    localparam int T_3US = 3;
    localparam int T_10US = 10;
    localparam int T_86US = 86;
    localparam int T_342US = 342;
    localparam int T_2731US = 2731;
    localparam int CYC_1US = T_1US * CLK_MHZ;
    localparam int CYC_3US = T_3US * CLK_MHZ;
    localparam int CYC_10US = T_10US * CLK_MHZ;
    localparam int CYC_86US = T_86US * CLK_MHZ;
    localparam int CYC_342US = T_342US * CLK_MHZ;
    localparam int CYC_2731US = T_2731US * CLK_MHZ;
    localparam int DLY_W = 20;
    // Diagnostic enable values
    localparam logic [7:0] DIAG_OFF = 8'h00;
    localparam logic [7:0] DIAG_ON = 8'h40;
    // Reset values
    localparam logic [7:0] RST_DIAGNOSTIC_ENABLE = 8'h00;
    localparam logic [7:0] RST_DELAY = 8'h02;
    localparam logic [7:0] RST_EDGE_EN = 8'h00;
    // Record set numbers and byte indexes
    localparam logic [7:0] REC_DIAGNOSTIC_ENABLE = 8'h00;
    localparam logic [7:0] REC_DELAY = 8'h01;
    localparam logic [7:0] REC_EDGE = 8'h80;
    localparam logic [7:0] IDX_RISE = 8'h00;
    localparam logic [7:0] IDX_FALL = 8'h01;
    localparam logic [7:0] REC_DIAG_SHORT = 8'h00;
    localparam logic [7:0] REC_DIAG_FULL = 8'h01;
    localparam logic [7:0] DIAG_SHORT_LEN = 8'h04;
    localparam logic [7:0] DIAG_FULL_LEN = 8'h14;
    // Diagnostic record byte positions
    localparam int POS_FAULT_SUM = 0;
    localparam int POS_CLASS = 1;
    localparam int POS_RSVD = 2;
    localparam int POS_OVF_LOST = 3;
    localparam int POS_CH_KIND = 4;
    localparam int POS_BITS_CH = 5;
    localparam int POS_CH_COUNT = 6;
    localparam int POS_LOST_EDGE = 7;
    localparam int POS_TS = 16;
    // Field positions
    localparam int BIT_MOD_FAIL = 0;
    localparam int BIT_EXT_ERR = 2;
    localparam int BIT_CH_ERR = 3;
    localparam int BIT_OVF = 3;
    localparam int BIT_LOST = 6;
    // Constant record bytes
    localparam logic [7:0] VAL_CLASS = 8'h1f;
    localparam logic [7:0] VAL_CH_KIND = 8'h70;
    localparam logic [7:0] VAL_BITS_CH = 8'h00;
    localparam logic [7:0] VAL_CH_COUNT = 8'h04;

    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] snap;
        logic [15:0] stamp;
    } fcie_event_t;

    typedef enum logic [1:0] {
        DG_IDLE = 2'b00,
        DG_ACTIVE = 2'b01,
        DG_GOING = 2'b11
    } fcie_diag_st_t;
endpackage

// >>> design/fcie_ticker.sv
// Free-running 32-bit microsecond ticker
`timescale 1ns/1ps
`default_nettype none
module fcie_ticker
    import fcie_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    output logic [31:0] us_count
);
    localparam logic [7:0] PRE_LAST = 8'(CLK_MHZ - 1);
    logic [7:0] pre_r;
    wire us_tick = (pre_r == PRE_LAST);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_r <= 8'h00;
            us_count <= 32'h0000_0000;
        end else begin
            pre_r <= us_tick ? 8'h00 : pre_r + 8'h01;
            if (us_tick) begin
                us_count <= us_count + 32'h0000_0001;
            end
        end
    end

    property p_tick_step;
        @(posedge ref_clk) disable iff (rst)
        us_tick |=> (us_count == $past(us_count) + 32'h0000_0001);
    endproperty
    a_tick_step: assert property (p_tick_step) else $error("ticker did not advance");
endmodule
`default_nettype wire

// >>> design/fcie_top.sv
// Four-channel filtered input unit with edge events and diagnostic record
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Diagnostic enable: 00h off, 40h on, reset 00h
// - Per-channel delay codes 00h/02h/04h, reset 02h
// - Codes 07h/09h/0Ch too; others not allowed (the code stores them and filters with the 3 us delay)
// - Rising enable bits 0-3 per channel
// - Falling enable bits 0-3 per channel
// - Both edge enables reset to zero
// - Edges process interrupt; losses diagnostic interrupt
// - Event mask bits 0-3, upper zero
// - Snapshot holds filtered levels at event
// - 32-bit microsecond counter from zero, wraps
// - Event stamp is counter low 16 bits
// - Incoming diagnostic, automatic going when cleared
// - Events inside diagnostic window are discarded
// - Fault lamp on during diagnostic window
// - Record 01h whole, 00h first four
// - Fault summary bits 0, 2, 3
// - Module class byte constant 1Fh
// - Overflow flag in bit 3
// - Lost process interrupt flag in bit 6
// - Constant bytes 70h, 00h, 04h
// - Lost edge flags per channel bits 0-3
// - Record ends with full ticker stamp
module fcie_top
    import fcie_pkg::*;
#(
    parameter int DLY_86 = CYC_86US,
    parameter int DLY_342 = CYC_342US,
    parameter int DLY_2731 = CYC_2731US
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [NCH-1:0] din,
    input wire logic par_wr,
    input wire logic diag_rd,
    input wire logic [7:0] record_set_number,
    input wire logic [7:0] object_index,
    input wire logic [7:0] par_wdata,
    input wire logic event_ack,
    output logic [7:0] rd_data_r,
    output logic rd_valid_r,
    output logic rd_err_r,
    output logic proc_irq_r,
    output fcie_event_t event_r,
    output logic diag_in_irq_r,
    output logic diag_go_irq_r,
    output logic module_fault_lamp_r,
    output logic [NCH-1:0] level_r
);
    function automatic logic [DLY_W-1:0] delay_of(input logic [7:0] code);
        case (code)
            CODE_1US: delay_of = DLY_W'(CYC_1US);
            CODE_3US: delay_of = DLY_W'(CYC_3US);
            CODE_10US: delay_of = DLY_W'(CYC_10US);
            CODE_86US: delay_of = DLY_W'(DLY_86);
            CODE_342US: delay_of = DLY_W'(DLY_342);
            CODE_2731US: delay_of = DLY_W'(DLY_2731);
            default: delay_of = DLY_W'(CYC_3US);
        endcase
    endfunction

    logic [7:0] diagnostic_enable_r;
    logic [7:0] delay_code_r [NCH];
    logic [7:0] rise_en_r;
    logic [7:0] fall_en_r;
    logic [NCH-1:0] filt;
    logic [NCH-1:0] prev_r;
    logic [31:0] us_count;
    logic pending_r;
    logic lost_r;
    logic ovf_r;
    logic [NCH-1:0] lost_edge_r;
    logic [31:0] fault_ts_r;
    fcie_diag_st_t st_r;
    fcie_diag_st_t st_nxt;
    logic [7:0] diag_rec [20];

    fcie_ticker u_ticker (
        .ref_clk(ref_clk),
        .rst(rst),
        .us_count(us_count)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            fcie_filter u_filt (
                .ref_clk(ref_clk),
                .rst(rst),
                .pin(din[gi]),
                .delay_cycles(delay_of(delay_code_r[gi])),
                .level(filt[gi])
            );
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    delay_code_r[gi] <= RST_DELAY;
                end else if (par_wr && record_set_number == REC_DELAY && object_index == 8'(gi)) begin
                    delay_code_r[gi] <= par_wdata;
                end
            end
        end
    endgenerate

    // Parameter write decode
    wire wr_diagnostic_enable = par_wr && record_set_number == REC_DIAGNOSTIC_ENABLE && object_index == 8'h00;
    wire wr_rise = par_wr && record_set_number == REC_EDGE && object_index == IDX_RISE;
    wire wr_fall = par_wr && record_set_number == REC_EDGE && object_index == IDX_FALL;

    // Edge detection and event decision
    wire [NCH-1:0] rises = filt & ~prev_r;
    wire [NCH-1:0] falls = ~filt & prev_r;
    wire [NCH-1:0] events = (rises & rise_en_r[NCH-1:0]) | (falls & fall_en_r[NCH-1:0]);
    wire window = (st_r != DG_IDLE);
    wire any_event = (|events) && !window;
    wire busy = pending_r && !event_ack;
    wire deliver = any_event && !busy;
    wire lose = any_event && busy;
    wire diag_on = (diagnostic_enable_r == DIAG_ON);

    // Diagnostic record read decode
    wire rd_short = record_set_number == REC_DIAG_SHORT && object_index < DIAG_SHORT_LEN;
    wire rd_full = record_set_number == REC_DIAG_FULL && object_index < DIAG_FULL_LEN;
    wire rd_ok = rd_short || rd_full;
    wire rd_clear = diag_rd && record_set_number == REC_DIAG_FULL && object_index == DIAG_FULL_LEN - 8'h01;
    wire cause = lost_r || ovf_r;

    always_comb begin
        for (int i = 0; i < 20; i++) begin
            diag_rec[i] = 8'h00;
        end
        diag_rec[POS_FAULT_SUM][BIT_MOD_FAIL] = cause;
        diag_rec[POS_FAULT_SUM][BIT_EXT_ERR] = 1'b0;
        diag_rec[POS_FAULT_SUM][BIT_CH_ERR] = |lost_edge_r;
        diag_rec[POS_CLASS] = VAL_CLASS;
        diag_rec[POS_OVF_LOST][BIT_OVF] = ovf_r;
        diag_rec[POS_OVF_LOST][BIT_LOST] = lost_r;
        diag_rec[POS_CH_KIND] = VAL_CH_KIND;
        diag_rec[POS_BITS_CH] = VAL_BITS_CH;
        diag_rec[POS_CH_COUNT] = VAL_CH_COUNT;
        diag_rec[POS_LOST_EDGE] = {4'h0, lost_edge_r};
        for (int i = 0; i < 4; i++) begin
            diag_rec[POS_TS + i] = fault_ts_r[8*i +: 8];
        end
    end

    always_comb begin
        case (st_r)
            DG_IDLE: st_nxt = (cause && diag_on) ? DG_ACTIVE : DG_IDLE;
            DG_ACTIVE: st_nxt = cause ? DG_ACTIVE : DG_GOING;
            DG_GOING: st_nxt = DG_IDLE;
            default: st_nxt = DG_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            diagnostic_enable_r <= RST_DIAGNOSTIC_ENABLE;
            rise_en_r <= RST_EDGE_EN;
            fall_en_r <= RST_EDGE_EN;
        end else begin
            if (wr_diagnostic_enable) begin
                diagnostic_enable_r <= par_wdata;
            end
            if (wr_rise) begin
                rise_en_r <= {4'h0, par_wdata[NCH-1:0]};
            end
            if (wr_fall) begin
                fall_en_r <= {4'h0, par_wdata[NCH-1:0]};
            end
        end
    end

    // Process interrupt delivery
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_r <= '0;
            pending_r <= 1'b0;
            proc_irq_r <= 1'b0;
            event_r <= '0;
            level_r <= '0;
        end else begin
            prev_r <= filt;
            level_r <= filt;
            proc_irq_r <= deliver;
            if (deliver) begin
                pending_r <= 1'b1;
                event_r.mask <= {4'h0, events};
                event_r.snap <= {4'h0, filt};
                event_r.stamp <= us_count[15:0];
            end else if (event_ack) begin
                pending_r <= 1'b0;
            end
        end
    end

    // Diagnostic flags, set wins over the read clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lost_r <= 1'b0;
            ovf_r <= 1'b0;
            lost_edge_r <= '0;
        end else begin
            lost_r <= lose || (lost_r && !rd_clear);
            ovf_r <= (lose && lost_r) || (ovf_r && !rd_clear);
            lost_edge_r <= (lose ? events : '0) | (rd_clear ? '0 : lost_edge_r);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= DG_IDLE;
            diag_in_irq_r <= 1'b0;
            diag_go_irq_r <= 1'b0;
            module_fault_lamp_r <= 1'b0;
            fault_ts_r <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
            diag_in_irq_r <= (st_r == DG_IDLE) && (st_nxt == DG_ACTIVE);
            diag_go_irq_r <= (st_r == DG_ACTIVE) && (st_nxt == DG_GOING);
            module_fault_lamp_r <= (st_nxt != DG_IDLE);
            if (st_r == DG_IDLE && st_nxt == DG_ACTIVE) begin
                fault_ts_r <= us_count;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
            rd_err_r <= 1'b0;
        end else begin
            rd_valid_r <= diag_rd;
            rd_err_r <= diag_rd && !rd_ok;
            rd_data_r <= (diag_rd && rd_ok) ? diag_rec[object_index[4:0]] : 8'h00;
        end
    end

    // Checks
    sequence s_loss;
        lose;
    endsequence
    sequence s_incoming;
        diag_in_irq_r ##1 module_fault_lamp_r;
    endsequence

    property p_diag_reset;
        @(posedge ref_clk) $fell(rst) |-> (diagnostic_enable_r == RST_DIAGNOSTIC_ENABLE && rise_en_r == 8'h00 && fall_en_r == 8'h00);
    endproperty
    a_diag_reset: assert property (p_diag_reset) else $error("enable bytes not at reset value");

    property p_diag_off_quiet;
        @(posedge ref_clk) disable iff (rst)
        (diagnostic_enable_r == DIAG_OFF && st_r == DG_IDLE) |=> !diag_in_irq_r;
    endproperty
    a_diag_off_quiet: assert property (p_diag_off_quiet) else $error("incoming while disabled");

    property p_event_mask;
        @(posedge ref_clk) disable iff (rst)
        proc_irq_r |-> (event_r.mask[7:4] == 4'h0 && event_r.mask != 8'h00 && event_r.snap == {4'h0, level_r});
    endproperty
    a_event_mask: assert property (p_event_mask) else $error("event record malformed");

    property p_stamp;
        @(posedge ref_clk) disable iff (rst)
        deliver |=> (event_r.stamp == $past(us_count[15:0]) && proc_irq_r);
    endproperty
    a_stamp: assert property (p_stamp) else $error("event stamp wrong");

    property p_window_discard;
        @(posedge ref_clk) disable iff (rst)
        module_fault_lamp_r |-> !deliver && !lose;
    endproperty
    a_window_discard: assert property (p_window_discard) else $error("event taken in window");

    property p_loss_flag;
        @(posedge ref_clk) disable iff (rst)
        s_loss |=> lost_r && (lost_edge_r != '0) && !proc_irq_r;
    endproperty
    a_loss_flag: assert property (p_loss_flag) else $error("loss not flagged");

    property p_incoming;
        @(posedge ref_clk) disable iff (rst)
        (st_r == DG_IDLE && cause && diag_on) |=> s_incoming;
    endproperty
    a_incoming: assert property (p_incoming) else $error("no incoming diagnostic");

    property p_going;
        @(posedge ref_clk) disable iff (rst)
        (st_r == DG_ACTIVE && !cause) |=> diag_go_irq_r ##1 !module_fault_lamp_r;
    endproperty
    a_going: assert property (p_going) else $error("no going diagnostic");

    property p_read_const;
        @(posedge ref_clk) disable iff (rst)
        (diag_rd && record_set_number == REC_DIAG_FULL && object_index == 8'h04) |=> (rd_data_r == VAL_CH_KIND);
    endproperty
    a_read_const: assert property (p_read_const) else $error("channel kind byte wrong");

    property p_short_limit;
        @(posedge ref_clk) disable iff (rst)
        (diag_rd && record_set_number == REC_DIAG_SHORT && object_index >= DIAG_SHORT_LEN) |=> rd_err_r && rd_valid_r;
    endproperty
    a_short_limit: assert property (p_short_limit) else $error("short record overrun");

    property p_window_quiet;
        @(posedge ref_clk) disable iff (rst)
        (window && (|events)) |=> !proc_irq_r && $stable(event_r);
    endproperty
    a_window_quiet: assert property (p_window_quiet) else $error("event in window");

    property p_ts_capture;
        @(posedge ref_clk) disable iff (rst)
        diag_in_irq_r |-> (fault_ts_r == $past(us_count));
    endproperty
    a_ts_capture: assert property (p_ts_capture) else $error("fault stamp wrong");

    property p_overflow;
        @(posedge ref_clk) disable iff (rst)
        (lose && lost_r) |=> ovf_r;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_go_cause;
        @(posedge ref_clk) disable iff (rst)
        diag_go_irq_r |-> !cause;
    endproperty
    a_go_cause: assert property (p_go_cause) else $error("going with cause");

    property p_rd_idle;
        @(posedge ref_clk) disable iff (rst)
        !diag_rd |=> !rd_valid_r && (rd_data_r == 8'h00);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");

    property p_lost_edge;
        @(posedge ref_clk) disable iff (rst)
        lose |=> ((lost_edge_r & $past(events)) == $past(events));
    endproperty
    a_lost_edge: assert property (p_lost_edge) else $error("lost edge not flagged");
endmodule
`default_nettype wire

// >>> tb/fcie_host_model.sv
// Backplane host model: record writes and reads, event acknowledge
`timescale 1ns/1ps
`default_nettype none
module fcie_host_model
    import fcie_pkg::*;
(
    input wire logic ref_clk,
    input wire logic proc_irq_r,
    input wire logic rd_valid_r,
    input wire logic rd_err_r,
    input wire logic [7:0] rd_data_r,
    output logic par_wr,
    output logic diag_rd,
    output logic [7:0] record_set_number,
    output logic [7:0] object_index,
    output logic [7:0] par_wdata,
    output logic event_ack
);
    int ack_dly = 3;
    int ack_cnt = 0;
    logic ack_auto = 1'b0;
    logic ack_man = 1'b0;
    assign event_ack = ack_auto | ack_man;
    initial begin
        par_wr = 1'b0;
        diag_rd = 1'b0;
        record_set_number = 8'h00;
        object_index = 8'h00;
        par_wdata = 8'h00;
    end
    // Zero delay stalls the acknowledge
    always @(posedge ref_clk) begin
        ack_auto <= (proc_irq_r !== 1'b1) && (ack_cnt == 1);
        if (proc_irq_r === 1'b1) begin
            ack_cnt <= ack_dly;
        end else if (ack_cnt > 0) begin
            ack_cnt <= ack_cnt - 1;
        end
    end
    task automatic ack_pulse();
        @(posedge ref_clk);
        ack_man <= 1'b1;
        @(posedge ref_clk);
        ack_man <= 1'b0;
    endtask
    // Only called while the system is stopped
    task automatic wr(input logic [7:0] rec, input logic [7:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        par_wr <= 1'b1;
        record_set_number <= rec;
        object_index <= idx;
        par_wdata <= d;
        @(posedge ref_clk);
        par_wr <= 1'b0;
        record_set_number <= ~rec;
        object_index <= ~idx;
        par_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] rec, input logic [7:0] idx, output logic [7:0] d, output logic e);
        @(posedge ref_clk);
        diag_rd <= 1'b1;
        record_set_number <= rec;
        object_index <= idx;
        @(posedge ref_clk);
        diag_rd <= 1'b0;
        record_set_number <= ~rec;
        object_index <= ~idx;
        #1;
        d = (rd_valid_r === 1'b1) ? rd_data_r : 8'hxx;
        e = (rd_valid_r === 1'b1) ? rd_err_r : 1'bx;
    endtask
endmodule
`default_nettype wire

// >>> tb/fcie_top_tb.sv
// Self-checking bench of the four-channel input edge event unit
`timescale 1ns/1ps
`default_nettype none
module fcie_top_tb
    import fcie_pkg::*;
;
    localparam int D86 = 40;
    localparam int D342 = 60;
    localparam int D2731 = 80;
    logic ref_clk;
    logic rst;
    logic [NCH-1:0] din;
    logic [NCH-1:0] lv;
    logic [15:0] seed = 16'h4a16;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_in = 0;
    int n_go = 0;
    int t_in = 0;
    int dly_tab [6] = '{1 * CLK_MHZ, 3 * CLK_MHZ, 10 * CLK_MHZ, D86, D342, D2731};
    logic [7:0] code_tab [6] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c};
    wire logic par_wr, diag_rd, event_ack, rd_valid_r, rd_err_r, proc_irq_r;
    wire logic diag_in_irq_r, diag_go_irq_r, module_fault_lamp_r;
    wire logic [7:0] record_set_number, object_index, par_wdata, rd_data_r;
    wire logic [NCH-1:0] level_r;
    wire fcie_event_t event_r;
    fcie_top #(.DLY_86(D86), .DLY_342(D342), .DLY_2731(D2731)) fcie_top_inst (
        .ref_clk(ref_clk), .rst(rst), .din(din), .par_wr(par_wr), .diag_rd(diag_rd),
        .record_set_number(record_set_number), .object_index(object_index), .par_wdata(par_wdata),
        .event_ack(event_ack), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r), .rd_err_r(rd_err_r),
        .proc_irq_r(proc_irq_r), .event_r(event_r), .diag_in_irq_r(diag_in_irq_r),
        .diag_go_irq_r(diag_go_irq_r), .module_fault_lamp_r(module_fault_lamp_r), .level_r(level_r)
    );
    fcie_host_model fcie_host_model_inst (
        .ref_clk(ref_clk), .proc_irq_r(proc_irq_r), .rd_valid_r(rd_valid_r), .rd_err_r(rd_err_r),
        .rd_data_r(rd_data_r), .par_wr(par_wr), .diag_rd(diag_rd), .record_set_number(record_set_number),
        .object_index(object_index), .par_wdata(par_wdata), .event_ack(event_ack)
    );
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= rst ? 0 : cyc + 1;
        if (diag_in_irq_r === 1'b1) begin
            n_in <= n_in + 1;
            t_in <= cyc / CLK_MHZ;
        end
        if (diag_go_irq_r === 1'b1) n_go <= n_go + 1;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
    endfunction
    function automatic logic [7:0] exp_mask(input logic [3:0] o, input logic [3:0] n, input logic [7:0] re,
                                            input logic [7:0] fe);
        return {4'h0, (~o & n & re[3:0]) | (o & ~n & fe[3:0])};
    endfunction
    function automatic logic [7:0] cbyte(input int i);
        return (i == 1) ? 8'h1f : (i == 4) ? 8'h70 : (i == 6) ? 8'h04 : 8'h00;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string what);
        tests_run++;
        if ($isunknown(got) || $signed(got) < lo || $signed(got) > hi) begin
            num_errors++;
            $display("[ERR] %0t %s got %0d exp %0d..%0d", $time, what, $signed(got), lo, hi);
        end
    endtask
    task automatic rdchk(input logic [7:0] rec, input logic [7:0] idx, input logic [7:0] exp, input logic err);
        logic [7:0] d;
        logic e;
        fcie_host_model_inst.rd(rec, idx, d, e);
        chk(32'(d), 32'(exp), "read byte");
        chk(32'(e), 32'(err), "read error");
    endtask
    // Drive a level and watch filter and event outputs
    task automatic apply(input logic [3:0] v, input int dly, input logic [7:0] m);
        int t_lv;
        int n_ev;
        int est;
        fcie_event_t ev;
        t_lv = -1;
        n_ev = 0;
        est = 0;
        ev = '0;
        @(posedge ref_clk);
        din <= v;
        for (int i = 0; i < dly + 12; i++) begin
            @(posedge ref_clk);
            #1;
            if (t_lv < 0 && level_r !== lv) t_lv = i;
            if (proc_irq_r === 1'b1) begin
                n_ev++;
                ev = event_r;
                est = cyc / CLK_MHZ;
            end
        end
        if (v !== lv) chk_rng(32'(t_lv), dly, dly + 8, "filter delay");
        chk(32'(level_r), 32'(v), "filtered level");
        chk(32'(n_ev), (m != 8'h00) ? 32'd1 : 32'd0, "event count");
        if (m != 8'h00) begin
            chk(32'(ev.mask), 32'(m), "event mask");
            chk(32'(ev.snap), 32'(v), "event snapshot");
            chk_rng(32'(ev.stamp), est - 2, est + 2, "event stamp");
        end
        lv = v;
    endtask
    task automatic glitch(input logic [3:0] v, input int len);
        int bad;
        bad = 0;
        @(posedge ref_clk);
        din <= v;
        repeat (len) @(posedge ref_clk);
        din <= lv;
        repeat (len + 20) begin
            @(posedge ref_clk);
            #1;
            if (level_r !== lv || proc_irq_r === 1'b1) bad++;
        end
        chk(32'(bad), 32'd0, "short pulse passed");
    endtask
    task automatic summarize();
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
    initial begin
        logic [7:0] re;
        logic [7:0] fe;
        logic [3:0] v;
        logic [7:0] b0;
        logic [7:0] b1;
        logic e;
        rst = 1'b1;
        din = '0;
        lv = '0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 20; i++) rdchk(REC_DIAG_FULL, 8'(i), cbyte(i), 1'b0);
        for (int i = 0; i < 4; i++) rdchk(REC_DIAG_SHORT, 8'(i), cbyte(i), 1'b0);
        rdchk(REC_DIAG_SHORT, 8'h04, 8'h00, 1'b1);
        rdchk(REC_DIAG_FULL, 8'h14, 8'h00, 1'b1);
        rdchk(8'h02, 8'h00, 8'h00, 1'b1);
        apply(4'hf, 3 * CLK_MHZ, 8'h00);
        apply(4'h0, 3 * CLK_MHZ, 8'h00);
        for (int k = 0; k < 6; k++) begin
            for (int c = 0; c < NCH; c++) fcie_host_model_inst.wr(REC_DELAY, 8'(c), code_tab[k]);
            apply(4'hf, dly_tab[k], 8'h00);
            apply(4'h0, dly_tab[k], 8'h00);
        end
        glitch(4'hf, D2731 - 10);
        for (int c = 0; c < NCH; c++) fcie_host_model_inst.wr(REC_DELAY, 8'(c), 8'h07);
        for (int k = 0; k < 30; k++) begin
            seed = lfsr_next(seed);
            re = (k == 0) ? 8'hff : seed[7:0];
            fe = (k == 0) ? 8'hff : seed[15:8];
            fcie_host_model_inst.ack_dly = seed[4] ? 1 : 30;
            fcie_host_model_inst.wr(REC_EDGE, IDX_RISE, re);
            fcie_host_model_inst.wr(REC_EDGE, IDX_FALL, fe);
            seed = lfsr_next(seed);
            v = (k == 0) ? ~lv : seed[3:0];
            apply(v, D86, exp_mask(lv, v, re, fe));
        end
        chk(32'(n_in), 32'd0, "diag irq on edge");
        // Stalled host: one delivered, one lost, then overflow
        fcie_host_model_inst.ack_dly = 0;
        fcie_host_model_inst.wr(REC_EDGE, IDX_RISE, 8'h01);
        fcie_host_model_inst.wr(REC_EDGE, IDX_FALL, 8'h01);
        apply(lv ^ 4'h1, D86, 8'h01);
        apply(lv ^ 4'h1, D86, 8'h00);
        apply(lv ^ 4'h1, D86, 8'h00);
        chk(32'(n_in), 32'd0, "diag irq while disabled");
        chk(32'(module_fault_lamp_r), 32'd0, "lamp while disabled");
        rdchk(REC_DIAG_FULL, 8'h00, 8'h09, 1'b0);
        rdchk(REC_DIAG_FULL, 8'h03, 8'h48, 1'b0);
        rdchk(REC_DIAG_FULL, 8'h07, 8'h01, 1'b0);
        fcie_host_model_inst.rd(REC_DIAG_FULL, 8'h13, b0, e);
        rdchk(REC_DIAG_FULL, 8'h00, 8'h00, 1'b0);
        fcie_host_model_inst.ack_pulse();
        // Diagnostic window with interrupts enabled
        fcie_host_model_inst.wr(REC_DIAGNOSTIC_ENABLE, 8'h00, 8'h40);
        apply(lv ^ 4'h1, D86, 8'h01);
        apply(lv ^ 4'h1, D86, 8'h00);
        chk(32'(n_in), 32'd1, "incoming diag irq");
        chk(32'(module_fault_lamp_r), 32'd1, "lamp on");
        fcie_host_model_inst.ack_pulse();
        apply(lv ^ 4'h1, D86, 8'h00);
        chk(32'(module_fault_lamp_r), 32'd1, "lamp held");
        fcie_host_model_inst.rd(REC_DIAG_FULL, 8'h10, b0, e);
        fcie_host_model_inst.rd(REC_DIAG_FULL, 8'h11, b1, e);
        chk_rng({16'h0, b1, b0}, t_in - 2, t_in + 2, "fault stamp");
        fcie_host_model_inst.rd(REC_DIAG_FULL, 8'h13, b0, e);
        repeat (4) @(posedge ref_clk);
        #1;
        chk(32'(n_go), 32'd1, "going diag irq");
        chk(32'(module_fault_lamp_r), 32'd0, "lamp off");
        fcie_host_model_inst.ack_dly = 3;
        apply(lv ^ 4'h1, D86, 8'h01);
        summarize();
    end
endmodule
`default_nettype wire
